//--- src/cpu_decode_pkg.sv
package cpu_decode_pkg;

  // opcodes handled in full, then low nibbles that mark a test or only change the cycle count or mode
  localparam logic [7:0] OP_COPY_A2X = 8'h97;
  localparam logic [7:0] OP_COPY_X2A = 8'h9f;
  localparam logic [7:0] OP_RESET    = 8'h9d;
  localparam logic [3:0] TEST_LO     = 4'hd;
  localparam logic [3:0] LO_MUL      = 4'h2;
  localparam logic [3:0] LO_RTI      = 4'h0;
  localparam logic [3:0] LO_RTS      = 4'h1;
  localparam logic [3:0] LO_SWI      = 4'h3;
  localparam logic [3:0] LO_STORE_A  = 4'h7;
  localparam logic [3:0] LO_STORE_X  = 4'hf;
  localparam logic [3:0] LO_JUMP     = 4'hc;
  localparam logic [3:0] LO_CALL     = 4'hd;

  // instruction class from the upper opcode nibble
  localparam logic [3:0] HI_BIT_BRANCH = 4'h0;
  localparam logic [3:0] HI_BIT_DIR    = 4'h1;
  localparam logic [3:0] HI_REL        = 4'h2;
  localparam logic [3:0] HI_RMW_DIR    = 4'h3;
  localparam logic [3:0] HI_RMW_ACC    = 4'h4;
  localparam logic [3:0] HI_RMW_IDX    = 4'h5;
  localparam logic [3:0] HI_RMW_IX1    = 4'h6;
  localparam logic [3:0] HI_RMW_IX     = 4'h7;
  localparam logic [3:0] HI_CTRL_A     = 4'h8;
  localparam logic [3:0] HI_CTRL_B     = 4'h9;
  localparam logic [3:0] HI_IMM        = 4'ha;
  localparam logic [3:0] HI_DIR        = 4'hb;
  localparam logic [3:0] HI_EXT        = 4'hc;
  localparam logic [3:0] HI_IX2        = 4'hd;
  localparam logic [3:0] HI_IX1        = 4'he;
  localparam logic [3:0] HI_IX         = 4'hf;

  // cycle counts
  localparam logic [3:0] CYC_COPY      = 4'h2;
  localparam logic [3:0] CYC_TEST_DIR  = 4'h4;
  localparam logic [3:0] CYC_TEST_INH  = 4'h3;
  localparam logic [3:0] CYC_TEST_IX1  = 4'h5;
  localparam logic [3:0] CYC_TEST_IX   = 4'h4;
  localparam logic [3:0] CYC_BIT       = 4'h5;
  localparam logic [3:0] CYC_REL       = 4'h3;
  localparam logic [3:0] CYC_RMW_DIR   = 4'h5;
  localparam logic [3:0] CYC_RMW_INH   = 4'h3;
  localparam logic [3:0] CYC_RMW_IX1   = 4'h6;
  localparam logic [3:0] CYC_RMW_IX    = 4'h5;
  localparam logic [3:0] CYC_MUL       = 4'hb;
  localparam logic [3:0] CYC_RET       = 4'h6;
  localparam logic [3:0] CYC_SWI       = 4'ha;
  localparam logic [3:0] CYC_INH       = 4'h2;
  localparam logic [3:0] CYC_IMM       = 4'h2;
  localparam logic [3:0] CYC_CALL_REL  = 4'h6;
  localparam logic [3:0] CYC_MEM_DIR   = 4'h3;
  localparam logic [3:0] CYC_MEM_EXT   = 4'h4;
  localparam logic [3:0] CYC_MEM_IX2   = 4'h5;
  localparam logic [3:0] CYC_MEM_IX1   = 4'h4;
  localparam logic [3:0] CYC_MEM_IX    = 4'h3;
  localparam logic [3:0] CYC_STORE_ADD = 4'h1;
  localparam logic [3:0] CYC_CALL_ADD  = 4'h2;
  localparam logic [3:0] CYC_JUMP_SUB  = 4'h1;

  // lengths in bytes
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // values after reset
  localparam logic [15:0] RESET_PC  = 16'h0000;
  localparam logic [7:0]  RESET_ACC = 8'h00;
  localparam logic [7:0]  RESET_IDX = 8'h00;
  localparam logic [3:0]  CNT_FIRST = 4'h1;

  typedef enum logic [3:0] {
    inherent_mode, immediate_mode, direct_mode, extended_mode,
    indexed_word_offset_mode, indexed_byte_offset_mode,
    indexed_no_offset_mode, relative_mode, bit_branch_mode, bit_direct_mode
  } mode_t;

  typedef enum logic [5:0] {
    S_FETCH = 6'b000001,
    S_OPC   = 6'b000010,
    S_OPR1  = 6'b000100,
    S_OPR2  = 6'b001000,
    S_DATA  = 6'b010000,
    S_PAD   = 6'b100000
  } state_t;

  // index register plus unsigned offset
  function automatic logic [15:0] idx_add(input logic [15:0] base,
                                          input logic [7:0]  x);
    return base + {8'h00, x};
  endfunction

  // negative and zero of a tested byte
  function automatic logic [1:0] nz_of(input logic [7:0] v);
    return {v[7], v == 8'h00};
  endfunction

endpackage

//--- src/opcode_decoder.sv
module opcode_decoder
  import cpu_decode_pkg::*;
(
  input  wire logic [7:0] i_opcode,
  output mode_t           o_mode,
  output logic [1:0]      o_len,
  output logic [3:0]      o_cycles,
  output logic            o_is_test,
  output logic            o_reads_mem
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic [3:0] base;

  assign hi = i_opcode[7:4];
  assign lo = i_opcode[3:0];

  // class from upper nibble, operation from lower nibble
  always_comb begin
    o_mode = inherent_mode;
    base   = CYC_INH;
    case (hi)
      HI_BIT_BRANCH: begin
        o_mode = bit_branch_mode;
        base   = CYC_BIT;
      end
      HI_BIT_DIR: begin
        o_mode = bit_direct_mode;
        base   = CYC_BIT;
      end
      HI_REL: begin
        o_mode = relative_mode;
        base   = CYC_REL;
      end
      HI_RMW_DIR: begin
        o_mode = direct_mode;
        base   = (lo == TEST_LO) ? CYC_TEST_DIR : CYC_RMW_DIR;
      end
      HI_RMW_ACC, HI_RMW_IDX: begin
        o_mode = inherent_mode;
        base   = (hi == HI_RMW_ACC && lo == LO_MUL) ? CYC_MUL
               : (lo == TEST_LO) ? CYC_TEST_INH : CYC_RMW_INH;
      end
      HI_RMW_IX1: begin
        o_mode = indexed_byte_offset_mode;
        base   = (lo == TEST_LO) ? CYC_TEST_IX1 : CYC_RMW_IX1;
      end
      HI_RMW_IX: begin
        o_mode = indexed_no_offset_mode;
        base   = (lo == TEST_LO) ? CYC_TEST_IX : CYC_RMW_IX;
      end
      HI_CTRL_A: begin
        o_mode = inherent_mode;
        base   = (lo == LO_RTI || lo == LO_RTS) ? CYC_RET
               : (lo == LO_SWI) ? CYC_SWI : CYC_INH;
      end
      HI_CTRL_B: begin
        o_mode = inherent_mode;
        base   = CYC_COPY;
      end
      HI_IMM: begin
        o_mode = (lo == LO_CALL) ? relative_mode : immediate_mode;
        base   = (lo == LO_CALL) ? CYC_CALL_REL : CYC_IMM;
      end
      HI_DIR: begin
        o_mode = direct_mode;
        base   = CYC_MEM_DIR;
      end
      HI_EXT: begin
        o_mode = extended_mode;
        base   = CYC_MEM_EXT;
      end
      HI_IX2: begin
        o_mode = indexed_word_offset_mode;
        base   = CYC_MEM_IX2;
      end
      HI_IX1: begin
        o_mode = indexed_byte_offset_mode;
        base   = CYC_MEM_IX1;
      end
      HI_IX: begin
        o_mode = indexed_no_offset_mode;
        base   = CYC_MEM_IX;
      end
      default: begin
        o_mode = inherent_mode;
        base   = CYC_INH;
      end
    endcase
  end

  // byte count and cycle count per opcode
  always_comb begin
    case (o_mode)
      inherent_mode, indexed_no_offset_mode: o_len = LEN_ONE;
      extended_mode, indexed_word_offset_mode,
      bit_branch_mode:                       o_len = LEN_THREE;
      default:                               o_len = LEN_TWO;
    endcase
    o_cycles = base;
    if (hi >= HI_DIR) begin
      if (lo == LO_STORE_A || lo == LO_STORE_X) begin
        o_cycles = base + CYC_STORE_ADD;
      end else if (lo == LO_CALL) begin
        o_cycles = base + CYC_CALL_ADD;
      end else if (lo == LO_JUMP) begin
        o_cycles = base - CYC_JUMP_SUB;
      end
    end
  end

  // tests compare against zero; only tests and bit branches read data
  assign o_is_test   = (lo == TEST_LO) && (hi >= HI_RMW_DIR)
                    && (hi <= HI_RMW_IX);
  assign o_reads_mem = (o_is_test && hi != HI_RMW_ACC && hi != HI_RMW_IDX)
                    || (o_mode == bit_branch_mode);

endmodule // opcode_decoder

//--- src/cpu_transfer_test_decode_part.sv
// Summary of operation
// - opcode 97 copies acc to index in 2 cycles, flags kept.
// - opcode 9F copies index to acc in 2 cycles, flags kept.
// - tests 3D/4D/5D/6D/7D compare to zero, store nothing, 4/3/3/5/4 cycles.
// - direct mode takes one byte as the low address with a zero high byte.
// - bit branch fetches address then signed offset, added to pc if taken.
// - extended mode fetches high then low byte as the 16-bit address.
// - word-offset mode fetches high then low offset, added to the index.
// - byte-offset mode fetches one unsigned offset, added to the index.
// - upper opcode nibble picks the class, lower nibble the operation.
// - each opcode fetches its byte count and spends at least its cycle count (immediate ops and direct and extended jumps take one more).
module cpu_transfer_test_decode_part
  import cpu_decode_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_mem_data,
  output logic      [15:0] o_mem_addr,
  output logic             o_mem_rd,
  output logic      [7:0]  o_acc,
  output logic      [7:0]  o_index,
  output logic             o_flag_n,
  output logic             o_flag_z,
  output logic             o_flag_c,
  output logic      [15:0] o_pc,
  output logic      [15:0] o_eff_addr,
  output logic             o_eff_valid,
  output logic             o_instr_done,
  output logic             o_branch_taken
);

  typedef struct packed {
    state_t      st;
    logic [3:0]  cnt;
    logic [15:0] pc;
    logic [7:0]  opcode;
    logic [7:0]  opr1;
    logic [7:0]  opr2;
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic        n;
    logic        z;
    logic        c;
    logic [15:0] ea;
    logic        ea_valid;
    logic        done;
    logic        br_taken;
  } core_t;

  core_t       r;
  core_t       nx;
  logic [7:0]  op_in;
  mode_t       d_mode;
  logic [1:0]  d_len;
  logic [3:0]  d_cycles;
  logic        d_is_test;
  logic        d_reads;
  logic        fin;
  logic        bit_val;

  ////////////////////////////////////////////////////////////////////////////
  // decode the fresh opcode byte in its arrival cycle, else the held one
  assign op_in = (r.st == S_OPC) ? i_mem_data : r.opcode;

  opcode_decoder u_dec (
    .i_opcode    (op_in),
    .o_mode      (d_mode),
    .o_len       (d_len),
    .o_cycles    (d_cycles),
    .o_is_test   (d_is_test),
    .o_reads_mem (d_reads)
  );

  assign bit_val = i_mem_data[r.opcode[3:1]];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: opcode, operand bytes, data read, then pad to cycle count
  always_comb begin
    nx          = r;
    nx.ea_valid = 1'b0;
    fin         = 1'b0;
    o_mem_rd    = 1'b0;
    o_mem_addr  = r.pc;
    case (r.st)
      S_FETCH: begin
        o_mem_rd    = 1'b1;
        nx.pc       = r.pc + 16'h0001;
        nx.br_taken = 1'b0;
        nx.st       = S_OPC;
      end
      S_OPC: begin
        nx.opcode = i_mem_data;
        if (d_len != LEN_ONE) begin
          o_mem_rd = 1'b1;
          nx.pc    = r.pc + 16'h0001;
          nx.st    = S_OPR1;
        end else if (d_mode == indexed_no_offset_mode) begin
          nx.ea       = {8'h00, r.idx};
          nx.ea_valid = 1'b1;
          if (d_reads) begin
            o_mem_rd   = 1'b1;
            o_mem_addr = {8'h00, r.idx};
            nx.st      = S_DATA;
          end else begin
            fin = 1'b1;
          end
        end else begin
          if (i_mem_data == OP_COPY_A2X) begin
            nx.idx = r.acc;
          end else if (i_mem_data == OP_COPY_X2A) begin
            nx.acc = r.idx;
          end else if (d_is_test) begin
            {nx.n, nx.z} = nz_of(i_mem_data[4] ? r.idx : r.acc);
          end
          fin = 1'b1;
        end
      end
      S_OPR1: begin
        nx.opr1 = i_mem_data;
        if (d_len == LEN_THREE) begin
          o_mem_rd = 1'b1;
          nx.pc    = r.pc + 16'h0001;
          nx.st    = S_OPR2;
        end else begin
          case (d_mode)
            direct_mode, bit_direct_mode: nx.ea = {8'h00, i_mem_data};
            indexed_byte_offset_mode:
              nx.ea = idx_add({8'h00, r.idx}, i_mem_data);
            relative_mode:
              nx.ea = r.pc + {{8{i_mem_data[7]}}, i_mem_data};
            default: nx.ea = r.ea;
          endcase
          nx.ea_valid = (d_mode != immediate_mode);
          if (d_reads) begin
            o_mem_rd   = 1'b1;
            o_mem_addr = nx.ea;
            nx.st      = S_DATA;
          end else begin
            fin = 1'b1;
          end
        end
      end
      S_OPR2: begin
        nx.opr2 = i_mem_data;
        case (d_mode)
          extended_mode: nx.ea = {r.opr1, i_mem_data};
          indexed_word_offset_mode:
            nx.ea = idx_add({r.opr1, i_mem_data}, r.idx);
          default: nx.ea = {8'h00, r.opr1};
        endcase
        nx.ea_valid = 1'b1;
        if (d_reads) begin
          o_mem_rd   = 1'b1;
          o_mem_addr = nx.ea;
          nx.st      = S_DATA;
        end else begin
          fin = 1'b1;
        end
      end
      S_DATA: begin
        if (d_is_test) begin
          {nx.n, nx.z} = nz_of(i_mem_data);
        end else if (d_mode == bit_branch_mode) begin
          nx.c = bit_val;
          if (bit_val != r.opcode[0]) begin
            nx.pc       = r.pc + {{8{r.opr2[7]}}, r.opr2};
            nx.br_taken = 1'b1;
          end
        end
        fin = 1'b1;
      end
      S_PAD: begin
        fin = 1'b1;
      end
      default: begin
        nx.st = S_FETCH;
      end
    endcase
    // finish only once the listed cycle count is spent
    if (fin) begin
      nx.st = (r.cnt >= d_cycles) ? S_FETCH : S_PAD;
    end
    nx.done = (nx.st == S_FETCH) && (r.st != S_FETCH);
    nx.cnt  = (nx.st == S_FETCH) ? CNT_FIRST : r.cnt + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= '{st: S_FETCH, cnt: CNT_FIRST, pc: RESET_PC, opcode: OP_RESET,
             opr1: 8'h00, opr2: 8'h00, acc: RESET_ACC, idx: RESET_IDX,
             n: 1'b0, z: 1'b0, c: 1'b0, ea: 16'h0000, ea_valid: 1'b0,
             done: 1'b0, br_taken: 1'b0};
    end else begin
      r <= nx;
    end
  end

  // outputs straight from the state register
  assign o_acc          = r.acc;
  assign o_index        = r.idx;
  assign o_flag_n       = r.n;
  assign o_flag_z       = r.z;
  assign o_flag_c       = r.c;
  assign o_pc           = r.pc;
  assign o_eff_addr     = r.ea;
  assign o_eff_valid    = r.ea_valid;
  assign o_instr_done   = r.done;
  assign o_branch_taken = r.br_taken;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] instr_pc_r;

  // start address of the running instruction, for the length check
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      instr_pc_r <= RESET_PC;
    end else if (r.st == S_FETCH) begin
      instr_pc_r <= r.pc;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_copy_a2x: assert property ((r.st == S_OPC && i_mem_data == OP_COPY_A2X)
    |=> (r.idx == $past(r.acc)) && $stable({r.n, r.z, r.c})
        && r.st == S_FETCH && r.done)
    else $error("acc to index copy wrong");

  a_copy_x2a: assert property ((r.st == S_OPC && i_mem_data == OP_COPY_X2A)
    |=> (r.acc == $past(r.idx)) && $stable({r.n, r.z, r.c})
        && r.st == S_FETCH)
    else $error("index to acc copy wrong");

  a_test_cycles: assert property ((r.st != S_FETCH && nx.st == S_FETCH
      && op_in[3:0] == TEST_LO && op_in[7:4] >= HI_RMW_DIR
      && op_in[7:4] <= HI_RMW_IX)
    |-> r.cnt == ((op_in[7:4] == HI_RMW_DIR) ? 4'h4
               : (op_in[7:4] == HI_RMW_IX1) ? 4'h5
               : (op_in[7:4] == HI_RMW_IX) ? 4'h4 : 4'h3))
    else $error("test cycle count wrong");

  a_test_flags: assert property ((r.st == S_DATA && d_is_test)
    |=> r.n == $past(i_mem_data[7]) && r.z == ($past(i_mem_data) == 8'h00)
        && $stable(r.c) && $stable(r.acc))
    else $error("test flags wrong");

  a_direct_addr: assert property ((r.st == S_OPR1 && d_mode == direct_mode)
    |=> r.ea_valid && r.ea == {8'h00, $past(i_mem_data)})
    else $error("direct address wrong");

  a_ext_addr: assert property ((r.st == S_OPR2 && d_mode == extended_mode)
    |=> r.ea_valid && r.ea == {$past(r.opr1), $past(i_mem_data)})
    else $error("extended address wrong");

  a_word_index: assert property ((r.st == S_OPR2
      && d_mode == indexed_word_offset_mode)
    |=> r.ea == {$past(r.opr1), $past(i_mem_data)} + {8'h00, r.idx})
    else $error("word offset address wrong");

  a_byte_index: assert property ((r.st == S_OPR1
      && d_mode == indexed_byte_offset_mode)
    |=> r.ea == {8'h00, r.idx} + {8'h00, $past(i_mem_data)})
    else $error("byte offset address wrong");

  a_bit_branch: assert property ((r.st == S_DATA && d_mode == bit_branch_mode)
    |=> r.c == $past(bit_val) && r.br_taken == ($past(bit_val)
        != $past(r.opcode[0])) && (!r.br_taken || r.pc == $past(r.pc)
        + {{8{$past(r.opr2[7])}}, $past(r.opr2)}))
    else $error("bit branch wrong");

  a_class_decode: assert property ((r.st == S_OPC
      && i_mem_data[7:4] == HI_EXT)
    |-> d_mode == extended_mode && d_len == LEN_THREE)
    else $error("class decode wrong");

  a_fetch_len: assert property ((r.st == S_FETCH && r.done && !r.br_taken)
    |-> r.pc == instr_pc_r + {14'h0000, d_len})
    else $error("fetched byte count wrong");

  c_copy_a2x:    cover property (r.st == S_OPC && i_mem_data == OP_COPY_A2X);
  c_test_ix1:    cover property (r.done && r.opcode == 8'h6d);
  c_branch_take: cover property (r.br_taken && r.done);
  c_ext_fetch:   cover property (r.ea_valid && r.opcode[7:4] == HI_EXT);

endmodule // cpu_transfer_test_decode_part

//--- test/program_memory.sv
////////////////////////////////////////////////////////////////////////////////
// program memory on the far side of the fetch port
module program_memory (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:65535];

  // idle fill with no-ops so runaway fetches stay harmless
  initial begin
    foreach (mem[i]) mem[i] = 8'h9d;
    o_data = 8'h00;
  end

  // load a run of bytes starting at an address
  task automatic put(input logic [15:0] a, input logic [7:0] b[]);
    foreach (b[i]) mem[a + 16'(i)] = b[i];
  endtask

  // one-cycle read; without a request the bus shows the inverse
  always @(posedge i_sys_clk) begin
    if (i_rd === 1'b1) begin
      o_data <= mem[i_addr];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule // program_memory

//--- test/test_cpu_transfer_test_decode_part.sv
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the transfer and test decode fragment
module test_cpu_transfer_test_decode_part;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk;
  logic        rst;
  logic [7:0]  mem_data;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  acc;
  logic [7:0]  index;
  logic        fn;
  logic        fz;
  logic        fc;
  logic [15:0] pc;
  logic [15:0] eff_addr;
  logic        eff_valid;
  logic        done;
  logic        br;
  int          n_mismatch;
  int          comparisons;
  int          cycles;

  cpu_transfer_test_decode_part DUT (
    .i_sys_clk      (sys_clk),
    .i_rst          (rst),
    .i_mem_data     (mem_data),
    .o_mem_addr     (mem_addr),
    .o_mem_rd       (mem_rd),
    .o_acc          (acc),
    .o_index        (index),
    .o_flag_n       (fn),
    .o_flag_z       (fz),
    .o_flag_c       (fc),
    .o_pc           (pc),
    .o_eff_addr     (eff_addr),
    .o_eff_valid    (eff_valid),
    .o_instr_done   (done),
    .o_branch_taken (br)
  );

  program_memory mem_model (
    .i_sys_clk (sys_clk),
    .i_addr    (mem_addr),
    .i_rd      (mem_rd),
    .o_data    (mem_data)
  );

  // 50 MHz clock
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // report, compare, reset and step helpers
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string what);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask

  // reset, then land in the first fetch cycle
  task automatic do_reset();
    @(posedge sys_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    chk({pc, acc, index, fn, fz, fc, eff_addr} === 51'h0, "reset state");
    chk(mem_rd === 1'b1 && mem_addr === 16'h0000, "first fetch");
  endtask

  // run one instruction, count cycles and reads, judge the result
  task automatic step(input int cyc, input logic [15:0] npc,
                      input logic [3:0] nzcb, input int ea, input int rds);
    int n;
    int r;
    n = 0;
    r = 0;
    do begin
      r += int'(mem_rd === 1'b1);
      @(posedge sys_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    chk(n == cyc, $sformatf("cycle count %0d", n));
    chk(pc === npc, "program counter");
    chk({fn, fz, fc, br} === nzcb, "flags or branch");
    if (ea >= 0) chk(eff_addr === 16'(ea), "effective address");
    if (rds >= 0) chk(r == rds, $sformatf("read count %0d", r));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_copy();
    mem_model.put(16'h0000, '{8'h3d, 8'h20, 8'h97, 8'h9f});
    mem_model.put(16'h0020, '{8'h80});
    do_reset();
    step(4, 16'h0002, 4'b1000, 'h0020, 3);
    step(2, 16'h0003, 4'b1000, 'h0020, 1);
    chk(index === acc, "index copy");
    step(2, 16'h0004, 4'b1000, 'h0020, 1);
    chk(acc === index, "acc copy");
  endtask

  task automatic t_test();
    mem_model.put(16'h0000, '{8'h00, 8'h40, 8'h05});
    mem_model.put(16'h0008, '{8'h3d, 8'h41, 8'h4d, 8'h6d, 8'hfe,
                              8'h7d, 8'h3d, 8'h41, 8'h5d});
    mem_model.put(16'h0040, '{8'h01, 8'h80});
    mem_model.put(16'h00fe, '{8'hff});
    do_reset();
    step(5, 16'h0008, 4'b0011, -1, 4);
    step(4, 16'h000a, 4'b1010, 'h0041, 3);
    step(3, 16'h000b, 4'b0110, -1, 1);
    step(5, 16'h000d, 4'b1010, 'h00fe, 3);
    step(4, 16'h000e, 4'b0110, 'h0000, 2);
    step(4, 16'h0010, 4'b1010, 'h0041, 3);
    step(3, 16'h0011, 4'b0110, -1, 1);
  endtask

  task automatic t_branch();
    mem_model.put(16'h0000, '{8'h01, 8'h50, 8'h04, 8'h00, 8'h51, 8'hf0});
    mem_model.put(16'h0050, '{8'h03, 8'h01});
    do_reset();
    step(5, 16'h0003, 4'b0010, -1, 4);
    step(5, 16'hfff6, 4'b0011, -1, 4);
    @(posedge sys_clk);
    #1;
    chk(br === 1'b0, "branch flag clear");
  endtask

  task automatic t_modes();
    mem_model.put(16'h0000, '{8'hb6, 8'h34, 8'hc6, 8'h12, 8'h34,
                              8'hd6, 8'hab, 8'hcd, 8'he6, 8'hff,
                              8'hf6, 8'h9d, 8'hb7, 8'h34});
    do_reset();
    step(3, 16'h0002, 4'b0000, 'h0034, -1);
    step(4, 16'h0005, 4'b0000, 'h1234, -1);
    step(5, 16'h0008, 4'b0000, 'habcd, -1);
    step(4, 16'h000a, 4'b0000, 'h00ff, -1);
    step(3, 16'h000b, 4'b0000, 'h0000, -1);
    step(2, 16'h000c, 4'b0000, -1, 1);
    step(4, 16'h000e, 4'b0000, 'h0034, -1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  // main sequence
  initial begin
    rst = 1'b1;
    cycles = 0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    t_copy();
    t_test();
    t_branch();
    t_modes();
    results();
  end
endmodule // test_cpu_transfer_test_decode_part
